// File: design/afk_pkg.sv
// Constants and carrier types for the full search key builder.
// Assumes a single core clock; inputs come from same-clock classifier logic.
// Behaviour
// - Key type code in bits 1:0
// - Bit 2 high on first lookup only
// - Policy group byte from bit 3
// - Ingress port mask from bit 11, one-hot for ports 0-11
// - Bit 24 carries host lookup result
// - Bit 25 set for group DMAC
// - Bit 26 set for broadcast DMAC
// - Bit 27 set when frame tagged
// - Classified VID, DEI, PCP at 28..43
// - Hop limit nonzero, traffic class byte
// - Addresses at 53/181, equality at 309
// - Bit 310 set when next header TCP
// - Ports at 311/327, equality at 351
// - Range hit vector from bit 343
// - Ports from frame, VID/DSCP classified
// - Bit 352 seq zero or msgtype bit0
// - Bits 353-355 FIN/SYN/RST or msgtype
// - Bits 356-358 PSH/ACK/URG or flags
// - PTP domain 359, version 367
package afk_pkg;
  // ==========================================================
  // Key layout
  localparam int KEY_W       = 371;
  localparam int POS_TYPE    = 0;
  localparam int POS_FIRST   = 2;
  localparam int POS_PAG     = 3;
  localparam int POS_PORTS   = 11;
  localparam int POS_RSVD    = 23;
  localparam int POS_HOST    = 24;
  localparam int POS_MC      = 25;
  localparam int POS_BC      = 26;
  localparam int POS_TAGGED  = 27;
  localparam int POS_VID     = 28;
  localparam int POS_DEI     = 40;
  localparam int POS_PCP     = 41;
  localparam int POS_HOPNZ   = 44;
  localparam int POS_TCLASS  = 45;
  localparam int POS_DIP     = 53;
  localparam int POS_SIP     = 181;
  localparam int POS_IPEQ    = 309;
  localparam int POS_TCP     = 310;
  localparam int POS_DPORT   = 311;
  localparam int POS_SPORT   = 327;
  localparam int POS_RNG     = 343;
  localparam int POS_PEQ     = 351;
  localparam int POS_SEQ0    = 352;
  localparam int POS_FIN     = 353;
  localparam int POS_PSH     = 356;
  localparam int POS_DOM     = 359;
  localparam int POS_VER     = 367;
  localparam int NUM_PORTS   = 12;
  localparam int NUM_RNG     = 8;
  localparam int MAC_GROUP_BIT = 40;
  localparam logic [1:0] TYPE_IPV6_L4   = 2'h0;
  localparam logic [1:0] TYPE_IPV6_MISC = 2'h1;
  localparam logic [1:0] TYPE_CUSTOM    = 2'h2;
  localparam logic [7:0] PROTO_TCP      = 8'h06;
  localparam logic [47:0] MAC_BCAST     = 48'hffffffffffff;
  // ==========================================================
  // Range checker kinds
  typedef enum logic [2:0] {
    AFK_RNG_SPORT, AFK_RNG_DPORT, AFK_RNG_EITHER, AFK_RNG_VID,
    AFK_RNG_DSCP, AFK_RNG_OFF
  } afk_rng_kind_t;
  typedef struct packed {
    afk_rng_kind_t kind;
    logic [15:0]   lo;
    logic [15:0]   hi;
  } afk_rng_cfg_t;
  // ==========================================================
  // Parsed frame request
  typedef struct packed {
    logic [7:0]   policy_assoc_group;
    logic [3:0]   ingress_port;
    logic         host_match;
    logic [47:0]  dmac;
    logic         frame_has_qtag;
    logic [11:0]  vid;
    logic         dei;
    logic [2:0]   pcp;
    logic [5:0]   dscp;
    logic [7:0]   hop_limit;
    logic [7:0]   traffic_class_byte;
    logic [127:0] ipv6_dest_addr;
    logic [127:0] ipv6_src_addr;
    logic [7:0]   next_header;
    logic [15:0]  l4_dest_port;
    logic [15:0]  l4_src_port;
    logic [31:0]  tcp_seq;
    logic [5:0]   tcp_flags;
    logic         is_ptp;
    logic [3:0]   ptp_msg_type;
    logic [7:0]   ptp_flags_lo;
    logic         ptp_flag7;
    logic [7:0]   ptp_domain_number;
    logic [3:0]   ptp_version_field;
  } afk_frame_t;
endpackage : afk_pkg

// File: design/afk_key_builder.sv
// Full search key builder: two lookups per frame, key registered.
// Assumes frame fields are stable while req_valid is high.
`timescale 1ns/1ps
module afk_key_builder
  import afk_pkg::*;
#(
  parameter int RNG_N = NUM_RNG
)(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // Request
  input  wire logic                    req_valid,
  input  wire afk_frame_t              frame,
  input  wire afk_rng_cfg_t [RNG_N-1:0] rng_cfg,
  // Key out
  output logic                         key_valid,
  output logic [KEY_W-1:0]             key
);
  // ==========================================================
  // State
  typedef struct packed {
    logic             second;
    logic             valid;
    logic [KEY_W-1:0] key;
  } afk_state_t;
  afk_state_t st_ff;
  afk_state_t nxt_st;

  function automatic logic in_rng(input logic [15:0] v,
                                  input afk_rng_cfg_t c);
    in_rng = (v >= c.lo) && (v <= c.hi);
  endfunction : in_rng

  logic [RNG_N-1:0] hits;
  always_comb
  begin
    for (int i = 0; i < RNG_N; i++)
    begin
      case (rng_cfg[i].kind)
        AFK_RNG_SPORT:  hits[i] = in_rng(frame.l4_src_port, rng_cfg[i]);
        AFK_RNG_DPORT:  hits[i] = in_rng(frame.l4_dest_port, rng_cfg[i]);
        AFK_RNG_EITHER: hits[i] = in_rng(frame.l4_src_port, rng_cfg[i])
                               || in_rng(frame.l4_dest_port, rng_cfg[i]);
        AFK_RNG_VID:    hits[i] = in_rng({4'h0, frame.vid}, rng_cfg[i]);
        AFK_RNG_DSCP:   hits[i] = in_rng({10'h000, frame.dscp},
                                         rng_cfg[i]);
        default:        hits[i] = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Key assembly
  logic [KEY_W-1:0] k;
  logic             tcp;
  always_comb
  begin
    k   = '0;
    tcp = (frame.next_header == PROTO_TCP);
    k[POS_TYPE +: 2]   = TYPE_IPV6_L4;
    k[POS_FIRST]       = ~st_ff.second;
    k[POS_PAG +: 8]    = frame.policy_assoc_group;
    k[POS_PORTS +: NUM_PORTS] =
      NUM_PORTS'(12'h001 << frame.ingress_port);
    k[POS_RSVD]        = 1'b0;
    k[POS_HOST]        = frame.host_match;
    k[POS_MC]          = frame.dmac[MAC_GROUP_BIT];
    k[POS_BC]          = (frame.dmac == MAC_BCAST);
    k[POS_TAGGED]      = frame.frame_has_qtag;
    k[POS_VID +: 12]   = frame.vid;
    k[POS_DEI]         = frame.dei;
    k[POS_PCP +: 3]    = frame.pcp;
    k[POS_HOPNZ]       = (frame.hop_limit != 8'h00);
    k[POS_TCLASS +: 8] = frame.traffic_class_byte;
    k[POS_DIP +: 128]  = frame.ipv6_dest_addr;
    k[POS_SIP +: 128]  = frame.ipv6_src_addr;
    k[POS_IPEQ]        = (frame.ipv6_dest_addr == frame.ipv6_src_addr);
    k[POS_TCP]         = tcp;
    k[POS_DPORT +: 16] = frame.l4_dest_port;
    k[POS_SPORT +: 16] = frame.l4_src_port;
    k[POS_PEQ]         = (frame.l4_dest_port == frame.l4_src_port);
    k[POS_RNG +: NUM_RNG] = NUM_RNG'(hits);
    // Flags mean TCP or PTP depending on the detected protocol
    if (tcp)
    begin
      k[POS_SEQ0]      = (frame.tcp_seq == 32'h0);
      k[POS_FIN +: 3]  = frame.tcp_flags[2:0];
      k[POS_PSH +: 3]  = frame.tcp_flags[5:3];
    end
    else if (frame.is_ptp)
    begin
      k[POS_SEQ0]      = frame.ptp_msg_type[0];
      k[POS_FIN +: 3]  = frame.ptp_msg_type[3:1];
      k[POS_PSH +: 3]  = {frame.ptp_flag7, frame.ptp_flags_lo[2:1]};
      k[POS_DOM +: 8]  = frame.ptp_domain_number;
      k[POS_VER +: 4]  = frame.ptp_version_field;
    end
    // Plain UDP leaves the flag positions at zero
  end

  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.valid = req_valid;
    if (req_valid)
    begin
      nxt_st.key    = k;
      nxt_st.second = ~st_ff.second;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign key_valid = st_ff.valid;
  assign key       = st_ff.key;

  // ==========================================================
  // Checks
  property p_first;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_FIRST] == !$past(st_ff.second);
  endproperty
  a_first: assert property (p_first) else $error("first flag wrong");
  property p_type;
    @(posedge clock) disable iff (!nrst)
    key_valid |-> key[POS_TYPE +: 2] == TYPE_IPV6_L4;
  endproperty
  a_type: assert property (p_type) else $error("type code wrong");
  property p_onehot;
    @(posedge clock) disable iff (!nrst)
    req_valid && (frame.ingress_port < NUM_PORTS)
      |=> $onehot(key[POS_PORTS +: NUM_PORTS])
      && key[POS_PORTS + $past(frame.ingress_port)];
  endproperty
  a_onehot: assert property (p_onehot) else $error("port mask bad");
  property p_bc;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_BC] == ($past(frame.dmac) == MAC_BCAST);
  endproperty
  a_bc: assert property (p_bc) else $error("broadcast flag bad");
  property p_mc;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_MC] == $past(frame.dmac[MAC_GROUP_BIT]);
  endproperty
  a_mc: assert property (p_mc) else $error("multicast flag bad");
  property p_tcp;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_TCP] == ($past(frame.next_header) == PROTO_TCP);
  endproperty
  a_tcp: assert property (p_tcp) else $error("tcp flag bad");
  property p_peq;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_PEQ] ==
      ($past(frame.l4_src_port) == $past(frame.l4_dest_port));
  endproperty
  a_peq: assert property (p_peq) else $error("port equal bad");
  property p_udp0;
    @(posedge clock) disable iff (!nrst)
    req_valid && frame.next_header != PROTO_TCP && !frame.is_ptp
      |=> key[POS_SEQ0 +: 19] == '0;
  endproperty
  a_udp0: assert property (p_udp0) else $error("udp flags nonzero");
  property p_hop;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_HOPNZ] == ($past(frame.hop_limit) != 8'h00);
  endproperty
  a_hop: assert property (p_hop) else $error("hop flag bad");
  property p_nomask;
    @(posedge clock) disable iff (!nrst)
    req_valid && (frame.ingress_port >= NUM_PORTS)
      |=> key[POS_PORTS +: NUM_PORTS] == '0;
  endproperty
  a_nomask: assert property (p_nomask) else $error("mask not empty");
  property p_rsvd;
    @(posedge clock) disable iff (!nrst)
    key_valid |-> !key[POS_RSVD];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");
  property p_pag;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_PAG +: 8] == $past(frame.policy_assoc_group);
  endproperty
  a_pag: assert property (p_pag) else $error("group bad");
  property p_host;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_HOST] == $past(frame.host_match);
  endproperty
  a_host: assert property (p_host) else $error("host bad");
  property p_qtag;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_TAGGED] == $past(frame.frame_has_qtag);
  endproperty
  a_qtag: assert property (p_qtag) else $error("tag flag bad");
  property p_vid;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_VID +: 12] == $past(frame.vid)
      && key[POS_DEI] == $past(frame.dei)
      && key[POS_PCP +: 3] == $past(frame.pcp);
  endproperty
  a_vid: assert property (p_vid) else $error("vlan bad");
  property p_tcls;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_TCLASS +: 8] == $past(frame.traffic_class_byte);
  endproperty
  a_tcls: assert property (p_tcls) else $error("class bad");
  property p_addr;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_DIP +: 128] == $past(frame.ipv6_dest_addr)
      && key[POS_SIP +: 128] == $past(frame.ipv6_src_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address bad");
  property p_ipeq;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_IPEQ] ==
      ($past(frame.ipv6_dest_addr) == $past(frame.ipv6_src_addr));
  endproperty
  a_ipeq: assert property (p_ipeq) else $error("addr equal bad");
  property p_l4;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key[POS_DPORT +: 16] == $past(frame.l4_dest_port)
      && key[POS_SPORT +: 16] == $past(frame.l4_src_port);
  endproperty
  a_l4: assert property (p_l4) else $error("ports bad");

  // ==========================================================
  // Layer-4 flag checks
  property p_seq0;
    @(posedge clock) disable iff (!nrst)
    req_valid && frame.next_header == PROTO_TCP
      |=> key[POS_SEQ0] == ($past(frame.tcp_seq) == 32'h0);
  endproperty
  a_seq0: assert property (p_seq0) else $error("seq flag bad");
  property p_tflg;
    @(posedge clock) disable iff (!nrst)
    req_valid && frame.next_header == PROTO_TCP
      |=> key[POS_FIN +: 3] == $past(frame.tcp_flags[2:0]);
  endproperty
  a_tflg: assert property (p_tflg) else $error("tcp flags bad");
  property p_tflg2;
    @(posedge clock) disable iff (!nrst)
    req_valid && frame.next_header == PROTO_TCP
      |=> key[POS_PSH +: 3] == $past(frame.tcp_flags[5:3]);
  endproperty
  a_tflg2: assert property (p_tflg2) else $error("tcp flags hi");
  property p_tnop;
    @(posedge clock) disable iff (!nrst)
    req_valid && frame.next_header == PROTO_TCP
      |=> key[POS_DOM +: 12] == '0;
  endproperty
  a_tnop: assert property (p_tnop) else $error("ptp bits set");
  property p_pmsg;
    @(posedge clock) disable iff (!nrst)
    req_valid && frame.next_header != PROTO_TCP && frame.is_ptp
      |=> key[POS_SEQ0 +: 4] == $past(frame.ptp_msg_type);
  endproperty
  a_pmsg: assert property (p_pmsg) else $error("msg type bad");
  property p_pflg;
    @(posedge clock) disable iff (!nrst)
    req_valid && frame.next_header != PROTO_TCP && frame.is_ptp
      |=> key[POS_PSH +: 3] ==
      {$past(frame.ptp_flag7), $past(frame.ptp_flags_lo[2:1])};
  endproperty
  a_pflg: assert property (p_pflg) else $error("ptp flags bad");
  property p_pdom;
    @(posedge clock) disable iff (!nrst)
    req_valid && frame.next_header != PROTO_TCP && frame.is_ptp
      |=> key[POS_DOM +: 8] == $past(frame.ptp_domain_number)
      && key[POS_VER +: 4] == $past(frame.ptp_version_field);
  endproperty
  a_pdom: assert property (p_pdom) else $error("ptp domain bad");

  // ==========================================================
  // Range checker checks; only checkers that have a key bit
  localparam int RNG_K = (RNG_N < NUM_RNG) ? RNG_N : NUM_RNG;
  for (genvar g = 0; g < RNG_K; g++)
  begin : g_rng_chk
    property p_rng_off;
      @(posedge clock) disable iff (!nrst)
      req_valid && rng_cfg[g].kind == AFK_RNG_OFF |=> !key[POS_RNG + g];
    endproperty
    a_rng_off: assert property (p_rng_off) else $error("off hit");
    property p_rng_sp;
      @(posedge clock) disable iff (!nrst)
      req_valid && rng_cfg[g].kind == AFK_RNG_SPORT |=> key[POS_RNG + g] ==
        ($past(frame.l4_src_port) >= $past(rng_cfg[g].lo)
        && $past(frame.l4_src_port) <= $past(rng_cfg[g].hi));
    endproperty
    a_rng_sp: assert property (p_rng_sp) else $error("sport range");
    property p_rng_dp;
      @(posedge clock) disable iff (!nrst)
      req_valid && rng_cfg[g].kind == AFK_RNG_DPORT |=> key[POS_RNG + g] ==
        ($past(frame.l4_dest_port) >= $past(rng_cfg[g].lo)
        && $past(frame.l4_dest_port) <= $past(rng_cfg[g].hi));
    endproperty
    a_rng_dp: assert property (p_rng_dp) else $error("dport range");
    property p_rng_ei;
      @(posedge clock) disable iff (!nrst)
      req_valid && rng_cfg[g].kind == AFK_RNG_EITHER |=> key[POS_RNG + g] ==
        (($past(frame.l4_src_port) >= $past(rng_cfg[g].lo)
        && $past(frame.l4_src_port) <= $past(rng_cfg[g].hi))
        || ($past(frame.l4_dest_port) >= $past(rng_cfg[g].lo)
        && $past(frame.l4_dest_port) <= $past(rng_cfg[g].hi)));
    endproperty
    a_rng_ei: assert property (p_rng_ei) else $error("port range");
    property p_rng_vid;
      @(posedge clock) disable iff (!nrst)
      req_valid && rng_cfg[g].kind == AFK_RNG_VID |=> key[POS_RNG + g] ==
        ({4'h0, $past(frame.vid)} >= $past(rng_cfg[g].lo)
        && {4'h0, $past(frame.vid)} <= $past(rng_cfg[g].hi));
    endproperty
    a_rng_vid: assert property (p_rng_vid) else $error("vid range");
    property p_rng_ds;
      @(posedge clock) disable iff (!nrst)
      req_valid && rng_cfg[g].kind == AFK_RNG_DSCP |=> key[POS_RNG + g] ==
        ({10'h000, $past(frame.dscp)} >= $past(rng_cfg[g].lo)
        && {10'h000, $past(frame.dscp)} <= $past(rng_cfg[g].hi));
    endproperty
    a_rng_ds: assert property (p_rng_ds) else $error("dscp range");
  end

  // ==========================================================
  // Handshake checks; sampled nrst keeps the reset edge out
  property p_valid;
    @(posedge clock) disable iff (!nrst)
    req_valid |=> key_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("no key");
  property p_pulse;
    @(posedge clock) disable iff (!nrst)
    !req_valid |=> !key_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("extra key");
  property p_hold;
    @(posedge clock) disable iff (!nrst)
    nrst && !req_valid |=> $stable(key);
  endproperty
  a_hold: assert property (p_hold) else $error("key moved");
  property p_alt;
    @(posedge clock) disable iff (!nrst)
    req_valid ##1 req_valid |=> key[POS_FIRST] != $past(key[POS_FIRST]);
  endproperty
  a_alt: assert property (p_alt) else $error("no alternation");
endmodule : afk_key_builder

// File: tb/afk_match_model.sv
// Model of the match logic that consumes the search keys.
// Assumes keys arrive as one-cycle key_valid pulses on clock.
`timescale 1ns/1ps
module afk_match_model
  import afk_pkg::*;
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Key in
  input  wire logic             key_valid,
  input  wire logic [KEY_W-1:0] key,
  // Observed
  output logic [KEY_W-1:0]      seen_key
);
  // ==========================================================
  // Capture; entries never look at the reserved position
  always_ff @(posedge clock)
  begin
    if (!nrst)
      seen_key <= '0;
    else if (key_valid)
      seen_key <= key & ~(KEY_W'(1) << POS_RSVD);
  end
endmodule : afk_match_model

// File: tb/testbench.sv
// Self-checking bench for the full search key builder.
// Assumes the design package and the match model are compiled first.
`timescale 1ns/1ps
module testbench
  import afk_pkg::*;
;
  // ==========================================================
  // Signals
  logic                       clock = 1'b0;
  logic                       nrst = 1'b0;
  logic                       req_valid = 1'b0;
  afk_frame_t                 frame = '0;
  afk_rng_cfg_t [NUM_RNG-1:0] rng_cfg;
  logic                       key_valid;
  logic [KEY_W-1:0]           key;
  logic [KEY_W-1:0]           seen_key;
  int                         mismatches = 0;
  int                         n_tests = 0;
  int                         cycles = 0;

  afk_key_builder #(.RNG_N(NUM_RNG)) u_dut (.clock(clock), .nrst(nrst),
    .req_valid(req_valid), .frame(frame), .rng_cfg(rng_cfg),
    .key_valid(key_valid), .key(key));
  afk_match_model u_tcam (.clock(clock), .nrst(nrst),
    .key_valid(key_valid), .key(key), .seen_key(seen_key));

  initial
  begin
    forever #20 clock = ~clock;
  end
  // ==========================================================
  // Reference key
  function automatic logic in_r(logic [15:0] v, afk_rng_cfg_t c);
    return v >= c.lo && v <= c.hi;
  endfunction : in_r

  function automatic logic [KEY_W-1:0] exp_key(afk_frame_t f, logic first);
    logic [KEY_W-1:0] k;
    afk_rng_cfg_t     c;
    k = '0;
    k[2] = first;
    k[10:3] = f.policy_assoc_group;
    if (f.ingress_port < 4'hc)
      k[11 + f.ingress_port] = 1'b1;
    k[24] = f.host_match;
    k[25] = f.dmac[40];
    k[26] = &f.dmac;
    k[27] = f.frame_has_qtag;
    k[43:28] = {f.pcp, f.dei, f.vid};
    k[44] = |f.hop_limit;
    k[52:45] = f.traffic_class_byte;
    k[308:53] = {f.ipv6_src_addr, f.ipv6_dest_addr};
    k[309] = f.ipv6_src_addr == f.ipv6_dest_addr;
    k[310] = f.next_header == 8'h06;
    k[342:311] = {f.l4_src_port, f.l4_dest_port};
    k[351] = f.l4_src_port == f.l4_dest_port;
    for (int i = 0; i < NUM_RNG; i++)
    begin
      c = rng_cfg[i];
      case (c.kind)
        AFK_RNG_SPORT:  k[343+i] = in_r(f.l4_src_port, c);
        AFK_RNG_DPORT:  k[343+i] = in_r(f.l4_dest_port, c);
        AFK_RNG_EITHER: k[343+i] = in_r(f.l4_src_port, c)
                                   | in_r(f.l4_dest_port, c);
        AFK_RNG_VID:    k[343+i] = in_r({4'h0, f.vid}, c);
        AFK_RNG_DSCP:   k[343+i] = in_r({10'h0, f.dscp}, c);
        default:        k[343+i] = 1'b0;
      endcase
    end
    if (f.next_header == 8'h06)
      k[358:352] = {f.tcp_flags, f.tcp_seq == 32'h0};
    else if (f.is_ptp)
      k[370:352] = {f.ptp_version_field, f.ptp_domain_number, f.ptp_flag7,
                    f.ptp_flags_lo[2:1], f.ptp_msg_type};
    return k;
  endfunction : exp_key

  function automatic afk_frame_t mk(logic [3:0] p, logic [7:0] nh,
                                    logic ptp);
    afk_frame_t f;
    f = '0;
    f.policy_assoc_group = 8'ha5;
    f.ingress_port = p;
    f.host_match = p[0];
    f.dmac = 48'h0023456789a0 | {p[2], 40'h0} | p;
    f.frame_has_qtag = ~p[0];
    f.vid = 12'h00f;
    f.dei = 1'b1;
    f.pcp = 3'h5;
    f.dscp = 6'h2e;
    f.hop_limit = {7'h0, p[1]};
    f.traffic_class_byte = 8'h3c;
    f.ipv6_dest_addr = 128'h20010db8000000000000000000000001;
    f.ipv6_src_addr = f.ipv6_dest_addr ^ p;
    f.next_header = nh;
    f.l4_dest_port = 16'h0064;
    f.l4_src_port = 16'h0064 + p;
    f.tcp_seq = {28'h0, p};
    f.tcp_flags = 6'h2b ^ p;
    f.is_ptp = ptp;
    f.ptp_msg_type = 4'h9;
    f.ptp_flags_lo = 8'h86;
    f.ptp_flag7 = 1'b1;
    f.ptp_domain_number = 8'h5a;
    f.ptp_version_field = 4'h2;
    return f;
  endfunction : mk
  // ==========================================================
  // Tasks
  task automatic check(input logic ok, input string what);
    n_tests++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check

  // Back-to-back pair, as the classifier issues them
  task automatic do_pair(input afk_frame_t f);
    @(posedge clock);
    req_valid <= 1'b1;
    frame <= f;
    @(posedge clock);
    #1;
    check(key_valid === 1'b1 && key === exp_key(f, 1'b1), "first");
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    check(key_valid === 1'b1 && key === exp_key(f, 1'b0), "second");
    @(posedge clock);
    #1;
    check(key_valid === 1'b0 && seen_key === exp_key(f, 1'b0), "pulse");
  endtask : do_pair

  task automatic t_reset_mid();
    @(posedge clock);
    req_valid <= 1'b1;
    frame <= mk(4'h3, 8'h11, 1'b0);
    @(posedge clock);
    req_valid <= 1'b0;
    nrst <= 1'b0;
    @(posedge clock);
    nrst <= 1'b1;
    #1;
    check(key_valid === 1'b0 && key === '0, "reset");
    do_pair(mk(4'h3, 8'h11, 1'b0));
  endtask : t_reset_mid

  task automatic t_tcp_sweep();
    for (int p = 0; p < 14; p++)
      do_pair(mk(p[3:0], PROTO_TCP, 1'b0));
  endtask : t_tcp_sweep

  task automatic t_ptp_udp();
    do_pair(mk(4'h2, 8'h11, 1'b1));
    do_pair(mk(4'h1, PROTO_TCP, 1'b1));
  endtask : t_ptp_udp

  task automatic t_bcast_udp();
    afk_frame_t f;
    f = mk(4'h0, 8'h11, 1'b0);
    f.dmac = MAC_BCAST;
    f.l4_src_port = 16'h01f4;
    f.l4_dest_port = 16'hffff;
    f.vid = 12'h010;
    f.dscp = 6'h2d;
    do_pair(f);
  endtask : t_bcast_udp

  task automatic tally_and_finish();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // Sequence; timeout sized well above the roughly 80 cycles used
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    rng_cfg[0] <= '{AFK_RNG_SPORT, 16'h0064, 16'h0068};
    rng_cfg[1] <= '{AFK_RNG_DPORT, 16'h0064, 16'h00c8};
    rng_cfg[2] <= '{AFK_RNG_EITHER, 16'h01f4, 16'h01f4};
    rng_cfg[3] <= '{AFK_RNG_VID, 16'h000a, 16'h000f};
    rng_cfg[4] <= '{AFK_RNG_DSCP, 16'h002e, 16'h002e};
    rng_cfg[5] <= '{AFK_RNG_OFF, 16'h0000, 16'hffff};
    rng_cfg[6] <= '{AFK_RNG_SPORT, 16'h0000, 16'h0000};
    rng_cfg[7] <= '{AFK_RNG_DPORT, 16'hffff, 16'hffff};
    t_tcp_sweep();
    t_ptp_udp();
    t_bcast_udp();
    t_reset_mid();
    tally_and_finish();
  end
endmodule : testbench
